// *** mlf_cfg.svh ***
// Constants for the motor lock fault response block
`ifndef MLF_CFG_SVH
`define MLF_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and register map
// ----------------------------------------------------------------------------
`define MLF_CLK_HZ 50000000
`define MLF_OFS_SETUP1 8'h90
`define MLF_OFS_SETUP2 8'h94
`define MLF_OFS_STATUS 8'h98
`define MLF_OFS_MASK 8'h9C
`define MLF_OFS_CTRL 8'hA0
`define MLF_OFS_STATE 8'hA4
`define MLF_SETUP1_RST 32'h0000_0000
`define MLF_SETUP2_RST 32'h0000_0000
`define MLF_STATUS_RST 5'h00
`define MLF_MASK_RST 5'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MLF_RESP_HI 6
`define MLF_RESP_LO 3
`define MLF_RETRY_HI 2
`define MLF_RETRY_LO 0
`define MLF_SPDJ_EN_BIT 30
`define MLF_SYNC_EN_BIT 29
`define MLF_ABS_EN_BIT 28
`define MLF_OVS_HI 27
`define MLF_OVS_LO 24
`define MLF_SYNC_TIMES_HI 23
`define MLF_SYNC_TIMES_LO 21
`define MLF_MIN_SPD_HI 6
`define MLF_MIN_SPD_LO 4
`define MLF_CTRL_CLR_BIT 0
`define MLF_ST_SPDJ 0
`define MLF_ST_SYNC 1
`define MLF_ST_ABS 2
`define MLF_ST_SLOW 3
`define MLF_ST_RECOV 4
`define MLF_ST_W 5

// ----------------------------------------------------------------------------
// Response codes and timing figures
// ----------------------------------------------------------------------------
`define MLF_RESP_AUTO 4'h4
`define MLF_RESP_REPORT 4'h8
`define MLF_SYNC_BASE 4'h2
`define MLF_OVS_STEP_HZ 250
`define MLF_MS_PER_S 1000
`define MLF_RETRY_MS_0 100
`define MLF_RETRY_MS_1 500
`define MLF_RETRY_MS_2 1000
`define MLF_RETRY_MS_3 2000
`define MLF_RETRY_MS_4 3000
`define MLF_RETRY_MS_5 5000
`define MLF_RETRY_MS_6 7500
`define MLF_RETRY_MS_7 10000
// Minimum speeds in tenths of a hertz
`define MLF_DHZ_PER_HZ 10
`define MLF_MIN_DHZ_0 5
`define MLF_MIN_DHZ_1 10
`define MLF_MIN_DHZ_2 20
`define MLF_MIN_DHZ_3 30
`define MLF_MIN_DHZ_4 50
`define MLF_MIN_DHZ_5 100
`define MLF_MIN_DHZ_6 150
`define MLF_MIN_DHZ_7 250

`endif

// *** mlf_pkg.sv ***
// Types shared by the motor lock fault response block
package mlf_pkg;
  typedef enum logic [1:0] {
    MLF_IDLE = 2'b00,
    MLF_LATCHED = 2'b01,
    MLF_RETRY = 2'b10
  } mlf_state_t;

  typedef enum logic [1:0] {
    MLF_TRI = 2'b00,
    MLF_RECIRC = 2'b01,
    MLF_HS_BRAKE = 2'b10,
    MLF_LS_BRAKE = 2'b11
  } mlf_stage_t;
endpackage

// *** mlf_lock_resp.sv ***
// Motor lock detection, lock response state machine and APB registers
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "mlf_cfg.svh"

module mlf_lock_resp #(
  parameter int unsigned CLK_HZ = `MLF_CLK_HZ, // Cycle counts derive from this
  parameter int unsigned PER_W = 28 // Width of electrical period counts
) (
  input wire logic CLK_IN, // System clock
  input wire logic RESET_N_IN, // Synchronous reset, active low
  input wire logic PSEL_IN, // APB select
  input wire logic PENABLE_IN, // APB enable
  input wire logic PWRITE_IN, // APB write
  input wire logic [7:0] PADDR_IN, // APB byte address
  input wire logic [31:0] PWDATA_IN, // APB write data
  output logic [31:0] PRDATA_OUT, // APB read data
  output logic PREADY_OUT, // APB ready
  output logic PSLVERR_OUT, // APB error, unmapped address
  input wire logic MOTOR_RUN_IN, // Motor is being driven
  input wire logic EDGE_VALID_IN, // Electrical cycle measured, pulse
  input wire logic [PER_W-1:0] EDGE_PERIOD_IN, // Electrical period in clocks
  input wire logic SYNC_LOST_IN, // Commutation sync lost, pulse
  input wire logic NO_MOTOR_IN, // Phase current below absent motor level
  input wire logic [2:0] HS_CMD_IN, // Normal high-side switch commands
  input wire logic [2:0] LS_CMD_IN, // Normal low-side switch commands
  output logic [2:0] HS_ON_OUT, // High-side switches on
  output logic [2:0] LS_ON_OUT, // Low-side switches on
  output logic STAGE_HIZ_OUT, // Output stage tristated
  output logic RECIRC_OUT, // Output stage in recirculation
  output mlf_pkg::mlf_stage_t STAGE_MODE_OUT, // Stage state held by a lock
  output logic FAULT_IND_N_OUT, // Fault indicator, active low
  output logic IRQ_OUT // Interrupt, level
);
  import mlf_pkg::*;

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (CLK_HZ < `MLF_MS_PER_S)
    $error("CLK_HZ too low for millisecond counts");
  if ((64'(CLK_HZ) * `MLF_DHZ_PER_HZ / `MLF_MIN_DHZ_0) >= (64'h1 << PER_W))
    $error("PER_W too narrow for the slowest minimum speed");

  // --------------------------------------------------------------------------
  // Decoding functions
  // --------------------------------------------------------------------------
  localparam int unsigned CYC_PER_MS = CLK_HZ / `MLF_MS_PER_S;

  function automatic logic [PER_W-1:0] ovs_period(input logic [3:0] code);
    logic [PER_W-1:0] p;
    p = '0;
    for (int i = 0; i < 16; i++)
      if (code == 4'(i))
        p = PER_W'(CLK_HZ / (`MLF_OVS_STEP_HZ * (i + 1)));
    return p;
  endfunction

  function automatic logic [PER_W-1:0] min_period(input logic [2:0] code);
    logic [63:0] k;
    k = 64'(CLK_HZ) * `MLF_DHZ_PER_HZ;
    unique case (code)
      3'h0: return PER_W'(k / `MLF_MIN_DHZ_0);
      3'h1: return PER_W'(k / `MLF_MIN_DHZ_1);
      3'h2: return PER_W'(k / `MLF_MIN_DHZ_2);
      3'h3: return PER_W'(k / `MLF_MIN_DHZ_3);
      3'h4: return PER_W'(k / `MLF_MIN_DHZ_4);
      3'h5: return PER_W'(k / `MLF_MIN_DHZ_5);
      3'h6: return PER_W'(k / `MLF_MIN_DHZ_6);
      3'h7: return PER_W'(k / `MLF_MIN_DHZ_7);
    endcase
  endfunction

  function automatic logic [31:0] retry_cyc(input logic [2:0] code);
    unique case (code)
      3'h0: return 32'(`MLF_RETRY_MS_0 * CYC_PER_MS);
      3'h1: return 32'(`MLF_RETRY_MS_1 * CYC_PER_MS);
      3'h2: return 32'(`MLF_RETRY_MS_2 * CYC_PER_MS);
      3'h3: return 32'(`MLF_RETRY_MS_3 * CYC_PER_MS);
      3'h4: return 32'(`MLF_RETRY_MS_4 * CYC_PER_MS);
      3'h5: return 32'(`MLF_RETRY_MS_5 * CYC_PER_MS);
      3'h6: return 32'(`MLF_RETRY_MS_6 * CYC_PER_MS);
      3'h7: return 32'(`MLF_RETRY_MS_7 * CYC_PER_MS);
    endcase
  endfunction

  function automatic logic resp_latched(input logic [3:0] code);
    return code < `MLF_RESP_AUTO;
  endfunction

  function automatic logic resp_auto(input logic [3:0] code);
    return (code >= `MLF_RESP_AUTO) && (code < `MLF_RESP_REPORT);
  endfunction

  function automatic logic resp_off(input logic [3:0] code);
    return code > `MLF_RESP_REPORT;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == `MLF_OFS_SETUP1) || (a == `MLF_OFS_SETUP2) || (a == `MLF_OFS_STATUS) ||
           (a == `MLF_OFS_MASK) || (a == `MLF_OFS_CTRL) || (a == `MLF_OFS_STATE);
  endfunction

  // --------------------------------------------------------------------------
  // Registers and fields
  // --------------------------------------------------------------------------
  logic [31:0] setup1_r, setup2_r;
  logic [`MLF_ST_W-1:0] status_r, mask_r, events;
  mlf_state_t state_r;
  mlf_stage_t stage_r;
  logic [31:0] retry_cnt_r;
  logic [3:0] sync_cnt_r;
  logic [PER_W-1:0] since_edge_r;
  logic apb_acc, wr_fire, clr_fault;
  logic [3:0] resp;
  logic [2:0] retry_code, sync_times, min_code;
  logic det_arm, ovs_hit, sync_hit, abs_hit, slow_hit, lock_hit, recov;

  assign resp = setup1_r[`MLF_RESP_HI:`MLF_RESP_LO];
  assign retry_code = setup1_r[`MLF_RETRY_HI:`MLF_RETRY_LO];
  assign sync_times = setup2_r[`MLF_SYNC_TIMES_HI:`MLF_SYNC_TIMES_LO];
  assign min_code = setup2_r[`MLF_MIN_SPD_HI:`MLF_MIN_SPD_LO];

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // One wait state so that read data and ready come from flip-flops
  assign apb_acc = PSEL_IN && PENABLE_IN;
  assign wr_fire = apb_acc && PREADY_OUT && PWRITE_IN;
  assign clr_fault = wr_fire && (PADDR_IN == `MLF_OFS_CTRL) && PWDATA_IN[`MLF_CTRL_CLR_BIT];

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
    end
    else
    begin
      PREADY_OUT <= apb_acc && !PREADY_OUT;
      PSLVERR_OUT <= apb_acc && !PREADY_OUT && !addr_ok(PADDR_IN);
      PRDATA_OUT <= 32'h0000_0000;
      if (apb_acc && !PREADY_OUT && !PWRITE_IN)
        unique case (PADDR_IN)
          `MLF_OFS_SETUP1: PRDATA_OUT <= setup1_r;
          `MLF_OFS_SETUP2: PRDATA_OUT <= setup2_r;
          `MLF_OFS_STATUS: PRDATA_OUT <= 32'(status_r);
          `MLF_OFS_MASK: PRDATA_OUT <= 32'(mask_r);
          `MLF_OFS_STATE: PRDATA_OUT <= {26'h0, sync_cnt_r, state_r};
          default: PRDATA_OUT <= 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      setup1_r <= `MLF_SETUP1_RST;
      setup2_r <= `MLF_SETUP2_RST;
      mask_r <= `MLF_MASK_RST;
    end
    else if (wr_fire)
    begin
      if (PADDR_IN == `MLF_OFS_SETUP1)
        setup1_r <= PWDATA_IN;
      if (PADDR_IN == `MLF_OFS_SETUP2)
        setup2_r <= PWDATA_IN;
      if (PADDR_IN == `MLF_OFS_MASK)
        mask_r <= PWDATA_IN[`MLF_ST_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Lock detectors
  // --------------------------------------------------------------------------
  // Detectors rest while a lock action is in force, so one lock acts once
  assign det_arm = MOTOR_RUN_IN && (state_r == MLF_IDLE) && !resp_off(resp);
  assign ovs_hit = det_arm && setup2_r[`MLF_SPDJ_EN_BIT] && EDGE_VALID_IN &&
                   (EDGE_PERIOD_IN < ovs_period(setup2_r[`MLF_OVS_HI:`MLF_OVS_LO]));
  assign sync_hit = det_arm && setup2_r[`MLF_SYNC_EN_BIT] && SYNC_LOST_IN &&
                    ((sync_cnt_r + 4'h1) >= (4'(sync_times) + `MLF_SYNC_BASE));
  assign abs_hit = det_arm && setup2_r[`MLF_ABS_EN_BIT] && NO_MOTOR_IN;
  assign slow_hit = det_arm && (since_edge_r >= min_period(min_code));
  assign lock_hit = ovs_hit || sync_hit || abs_hit || slow_hit;
  assign recov = (state_r == MLF_RETRY) && (retry_cnt_r == 32'h0000_0000);

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN || !det_arm || !setup2_r[`MLF_SYNC_EN_BIT] || sync_hit)
      sync_cnt_r <= 4'h0;
    else if (SYNC_LOST_IN)
      sync_cnt_r <= sync_cnt_r + 4'h1;
  end

  // Time since the last electrical cycle; a stalled rotor gives no edges
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN || !det_arm || EDGE_VALID_IN)
      since_edge_r <= '0;
    else if (since_edge_r != '1)
      since_edge_r <= since_edge_r + 1'b1;
  end

  // --------------------------------------------------------------------------
  // Response state machine
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      state_r <= MLF_IDLE;
      stage_r <= MLF_TRI;
      retry_cnt_r <= 32'h0000_0000;
    end
    else
      unique case (state_r)
        MLF_IDLE:
          if (lock_hit && resp_latched(resp))
          begin
            state_r <= MLF_LATCHED;
            stage_r <= mlf_stage_t'(resp[1:0]);
          end
          else if (lock_hit && resp_auto(resp))
          begin
            state_r <= MLF_RETRY;
            stage_r <= mlf_stage_t'(resp[1:0]);
            retry_cnt_r <= retry_cyc(retry_code) - 32'h0000_0001;
          end
        MLF_LATCHED:
          if (clr_fault)
            state_r <= MLF_IDLE;
        MLF_RETRY:
          if (recov)
            state_r <= MLF_IDLE;
          else
            retry_cnt_r <= retry_cnt_r - 32'h0000_0001;
        default:
          state_r <= MLF_IDLE;
      endcase
  end

  // --------------------------------------------------------------------------
  // Output stage override
  // --------------------------------------------------------------------------
  // Report-only leaves state idle, so normal commands pass through
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      HS_ON_OUT <= 3'h0;
      LS_ON_OUT <= 3'h0;
      STAGE_HIZ_OUT <= 1'b0;
      RECIRC_OUT <= 1'b0;
      STAGE_MODE_OUT <= MLF_TRI;
    end
    else if (state_r != MLF_IDLE)
    begin
      HS_ON_OUT <= (stage_r == MLF_HS_BRAKE) ? 3'h7 : 3'h0;
      LS_ON_OUT <= (stage_r == MLF_LS_BRAKE) ? 3'h7 : 3'h0;
      STAGE_HIZ_OUT <= (stage_r == MLF_TRI);
      RECIRC_OUT <= (stage_r == MLF_RECIRC);
      STAGE_MODE_OUT <= stage_r;
    end
    else
    begin
      HS_ON_OUT <= HS_CMD_IN;
      LS_ON_OUT <= LS_CMD_IN;
      STAGE_HIZ_OUT <= 1'b0;
      RECIRC_OUT <= 1'b0;
      STAGE_MODE_OUT <= MLF_TRI;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
      FAULT_IND_N_OUT <= 1'b1;
    else
      FAULT_IND_N_OUT <= (state_r != MLF_LATCHED);
  end

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  assign events = {recov, slow_hit, abs_hit, sync_hit, ovs_hit};

  // New events win over a write-one-to-clear in the same cycle
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
      status_r <= `MLF_STATUS_RST;
    else if (wr_fire && (PADDR_IN == `MLF_OFS_STATUS))
      status_r <= (status_r & ~PWDATA_IN[`MLF_ST_W-1:0]) | events;
    else
      status_r <= status_r | events;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
      IRQ_OUT <= 1'b0;
    else
      IRQ_OUT <= |(status_r & mask_r);
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  property p_latch_on_lock;
    (lock_hit && resp_latched(resp)) |=> (state_r == MLF_LATCHED) ##1 !FAULT_IND_N_OUT;
  endproperty
  a_latch_on_lock: assert property (p_latch_on_lock) else $error("latched lock missing");

  property p_retry_load;
    (state_r == MLF_IDLE && lock_hit && resp_auto(resp)) |=>
      (state_r == MLF_RETRY) && (retry_cnt_r == retry_cyc($past(retry_code)) - 32'h1);
  endproperty
  a_retry_load: assert property (p_retry_load) else $error("retry wait not loaded");

  property p_retry_end;
    (state_r == MLF_RETRY && retry_cnt_r == 32'h0000_0001) |=> recov ##1 (state_r == MLF_IDLE);
  endproperty
  a_retry_end: assert property (p_retry_end) else $error("no recovery after wait");

  property p_report_only;
    (lock_hit && resp == `MLF_RESP_REPORT) |=>
      (state_r == MLF_IDLE) && (status_r != '0) ##1 FAULT_IND_N_OUT;
  endproperty
  a_report_only: assert property (p_report_only) else $error("report mode acted");

  property p_disabled;
    (resp_off(resp) && state_r == MLF_IDLE && !wr_fire) |=>
      (state_r == MLF_IDLE) && $stable(status_r[`MLF_ST_SLOW:`MLF_ST_SPDJ]);
  endproperty
  a_disabled: assert property (p_disabled) else $error("lock seen while disabled");

  property p_hs_brake;
    (state_r != MLF_IDLE && stage_r == MLF_HS_BRAKE) |=> (HS_ON_OUT == 3'h7) && (LS_ON_OUT == 3'h0);
  endproperty
  a_hs_brake: assert property (p_hs_brake) else $error("high-side brake wrong");

  property p_ls_brake;
    (state_r != MLF_IDLE && stage_r == MLF_LS_BRAKE) |=> (LS_ON_OUT == 3'h7) && (HS_ON_OUT == 3'h0);
  endproperty
  a_ls_brake: assert property (p_ls_brake) else $error("low-side brake wrong");

  property p_sync_count;
    sync_hit |-> (sync_cnt_r == 4'(sync_times) + `MLF_SYNC_BASE - 4'h1);
  endproperty
  a_sync_count: assert property (p_sync_count) else $error("sync loss count wrong");

  property p_latch_hold;
    (state_r == MLF_LATCHED && !clr_fault) |=> (state_r == MLF_LATCHED) && $stable(stage_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched fault dropped");

  property p_spdj_gate;
    !setup2_r[`MLF_SPDJ_EN_BIT] |=> !$rose(status_r[`MLF_ST_SPDJ]);
  endproperty
  a_spdj_gate: assert property (p_spdj_gate) else $error("speed detector not gated");

endmodule // mlf_lock_resp

// *** mlf_motor_model.sv ***
// Behavioural motor and power stage as seen from the lock logic
`timescale 1ns/1ps

module mlf_motor_model #(
  parameter int PER_W = 28 // Width of period reports
) (
  input wire logic clk_in, // System clock
  input wire logic [7:0] spin_per_in, // Clocks per electrical cycle, 0 stopped
  input wire logic slip_in, // Commanded sync slip
  input wire logic absent_in, // Motor disconnected
  output logic edge_valid_out, // Electrical cycle measured
  output logic [PER_W-1:0] edge_period_out, // Measured period
  output logic sync_lost_out, // Sync slip seen
  output logic no_motor_out // No phase current
);
  logic [7:0] cnt_r;
  logic hit;

  assign hit = (spin_per_in != 8'h00) && (cnt_r + 8'h01 >= spin_per_in);

  initial
  begin
    cnt_r = 8'h00;
    edge_valid_out = 1'b0;
    edge_period_out = '0;
    sync_lost_out = 1'b0;
    no_motor_out = 1'b0;
  end

  // Plain always so the start values above may share these variables
  always @(posedge clk_in)
  begin
    sync_lost_out <= slip_in;
    no_motor_out <= absent_in;
    cnt_r <= hit || spin_per_in == 8'h00 ? 8'h00 : cnt_r + 8'h01;
    edge_valid_out <= hit;
    // Period lines alternate between the last value and its inverse between reports
    edge_period_out <= hit ? PER_W'(spin_per_in) : ~edge_period_out;
  end
endmodule // mlf_motor_model

// *** motor_lock_fault_response_tb.sv ***
// Self-checking testbench for the motor lock fault response block
`timescale 1ns/1ps

module motor_lock_fault_response_tb;
  import mlf_pkg::*;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] hs_cmd = 3'h0;
  logic [2:0] ls_cmd = 3'h0;
  logic run = 1'b1;
  logic [7:0] spin = 8'h0A;
  logic slip = 1'b0;
  logic absent = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, edge_v, sync_l, no_mtr, hiz, recirc, fault_n, irq;
  logic [27:0] per;
  logic [2:0] hs_on, ls_on;
  mlf_stage_t mode;
  int seed = 28251;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int i, n;
  logic [31:0] v;
  logic [32:0] mon_e;
  logic [32:0] exp_q[$];
  int ms_tab[8] = '{100, 500, 1000, 2000, 3000, 5000, 7500, 10000};
  wire lock_act = hiz | recirc | (hs_on == 3'h7) | (ls_on == 3'h7);

  // One clock per millisecond keeps the retry waits short
  mlf_lock_resp #(.CLK_HZ(1000), .PER_W(28)) uut (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .MOTOR_RUN_IN(run),
    .EDGE_VALID_IN(edge_v), .EDGE_PERIOD_IN(per), .SYNC_LOST_IN(sync_l),
    .NO_MOTOR_IN(no_mtr), .HS_CMD_IN(hs_cmd), .LS_CMD_IN(ls_cmd), .HS_ON_OUT(hs_on),
    .LS_ON_OUT(ls_on), .STAGE_HIZ_OUT(hiz), .RECIRC_OUT(recirc),
    .STAGE_MODE_OUT(mode), .FAULT_IND_N_OUT(fault_n), .IRQ_OUT(irq));

  mlf_motor_model #(.PER_W(28)) motor (
    .clk_in(clk), .spin_per_in(spin), .slip_in(slip), .absent_in(absent),
    .edge_valid_out(edge_v), .edge_period_out(per), .sync_lost_out(sync_l),
    .no_motor_out(no_mtr));

  initial
  begin
    forever #10 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks++;
      if (g !== e)
      begin
        fails++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only pready or the bench timeout ends this wait
      do
        @(posedge clk);
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    begin
      exp_q.push_back({err, e});
      apb(1'b0, a, 32'h0);
    end
  endtask

  task pulse_slip;
    begin
      slip <= 1'b1;
      @(posedge clk);
      slip <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task wait_act(input int lim);
    begin
      n = 0;
      while (lock_act !== 1'b1 && n < lim)
      begin
        @(posedge clk);
        n++;
      end
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // --------------------------------------------------------------------------
  // Read monitor and timeout
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      mon_e = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_FFFF_FFFF;
      chk("read data", mon_e[31:0], prdata);
      chk("read error", 32'(mon_e[32]), 32'(pslverr));
    end
  end

  // Longest path is the eight retry waits, about 30000 clocks
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      wrap_up;
    end
  end

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    hs_cmd <= 3'($random(seed)) & 3'h3;
    ls_cmd <= 3'($random(seed)) & 3'h3;
    rd(8'h94, 32'h0);
    rd(8'h90, 32'h0);
    rd(8'h98, 32'h0);
    rd(8'h80, 32'h0, 1'b1);
    v = $random(seed);
    wr(8'h94, v);
    rd(8'h94, v);
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'h90, 32'(i) << 3);
      wr(8'h94, 32'h1000_0070);
      wr(8'h9C, 32'h4);
      absent <= 1'b1;
      wait_act(20);
      chk("indicator", 32'h0, 32'(fault_n));
      chk("mode", 32'(i), 32'(mode));
      chk("tristate", 32'(i == 0), 32'(hiz));
      chk("recirc", 32'(i == 1), 32'(recirc));
      chk("high side", i == 2 ? 32'h7 : 32'h0, 32'(hs_on));
      chk("low side", i == 3 ? 32'h7 : 32'h0, 32'(ls_on));
      chk("irq", 32'h1, 32'(irq));
      absent <= 1'b0;
      repeat (30) @(posedge clk);
      chk("held", 32'h1, 32'(lock_act & ~fault_n));
      rd(8'h98, 32'h4);
      rd(8'hA4, 32'h1);
      wr(8'hA0, 32'h1);
      wr(8'h98, 32'h1F);
      repeat (2) @(posedge clk);
      chk("cleared", 32'h1, 32'(fault_n & ~irq));
    end
    $display("test latched done");
    // Last pass stops the motor with the absent detector enabled
    for (i = 9; i < 18; i++)
    begin
      wr(8'h90, i < 16 ? 32'(i) << 3 : 32'h0);
      wr(8'h94, i != 16 ? 32'h1000_0070 : 32'h70);
      run <= (i != 17);
      absent <= 1'b1;
      repeat (20) @(posedge clk);
      rd(8'h98, 32'h0);
      chk("pass through", 32'(hs_cmd), 32'(hs_on));
      absent <= 1'b0;
    end
    // Let the absent report drain before the detectors rearm
    repeat (2) @(posedge clk);
    run <= 1'b1;
    $display("test disabled done");
    for (i = 0; i < 8; i++)
    begin
      wr(8'h90, (32'(4 + i % 4) << 3) | 32'(i));
      wr(8'h94, 32'h2000_0070 | (32'(7 - i) << 21));
      wr(8'h9C, 32'h10);
      repeat (8 - i) pulse_slip();
      chk("early sync lock", 32'h0, 32'(lock_act));
      pulse_slip();
      wait_act(10);
      chk("retry indicator", 32'h1, 32'(fault_n & lock_act));
      n = 1;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (lock_act === 1'b1 && n < 11000);
      chk("retry wait", 32'(ms_tab[i]), 32'(n - 1));
      repeat (2) @(posedge clk);
      chk("retry irq", 32'h1, 32'(irq));
      rd(8'h98, 32'h12);
      wr(8'h98, 32'h1F);
    end
    $display("test retry done");
    wr(8'h90, 32'h40);
    wr(8'h94, 32'h4100_0070);
    spin <= 8'h02;
    repeat (20) @(posedge clk);
    rd(8'h98, 32'h0);
    wr(8'h94, 32'h4000_0070);
    repeat (20) @(posedge clk);
    rd(8'h98, 32'h1);
    chk("report stage", 32'(ls_cmd), 32'(ls_on));
    chk("report indicator", 32'h1, 32'(fault_n));
    spin <= 8'h0A;
    wr(8'h98, 32'h1F);
    $display("test report done");
    wr(8'h90, 32'h0);
    wr(8'h94, 32'h70);
    spin <= 8'h00;
    repeat (28) @(posedge clk);
    chk("slow early", 32'h0, 32'(lock_act));
    wait_act(30);
    chk("slow lock", 32'h1, 32'(lock_act));
    rd(8'h98, 32'h8);
    spin <= 8'h0A;
    // The stall count rests at zero while latched; let edges resume before clearing, else it relocks
    repeat (12) @(posedge clk);
    wr(8'hA0, 32'h1);
    wr(8'h98, 32'h1F);
    $display("test min speed done");
    wrap_up;
  end
endmodule // motor_lock_fault_response_tb
